// File: verilog/fsp_top.sv
/*
 * fsp_top: sector write/erase protection logic with an APB slave.
 * assumes apb signals synchronous to clk_sys; rst_n is power-on or
 * hardware reset; bp_protect comes from the block protect decoder.
 */
// Decided for this implementation: register access over APB and the address map.
`timescale 1ns/1ps
module fsp_top #(
    parameter int SECTORS = 64,
    parameter int PROG_CYC = fsp_pkg::PAGE_PROG_CYC,
    parameter int ERASE_CYC = fsp_pkg::SECTOR_ERASE_CYC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // protection pins and inputs
    input wire logic write_protect_n,
    input wire logic [SECTORS-1:0] bp_protect,
    // protection results
    output logic [SECTORS-1:0] sector_protected,
    output logic write_in_progress,
    output logic status_locked
);
    import fsp_pkg::*;

    localparam int SW = $clog2(SECTORS);

    // elaboration checks: sector index needs a power of two
    if (SECTORS < 2 || SECTORS > 256 || (SECTORS & (SECTORS - 1)) != 0 ||
            PROG_CYC < 2 || ERASE_CYC < 2) begin : g_param_check
        $error("fsp_top: unsupported parameter values");
    end

    // storage
    logic [SECTORS-1:0] persistent_sector_bit; // non-volatile bits
    logic [SECTORS-1:0] dynamic_sector_bit; // volatile bits
    logic persistent_bit_lock; // lock over persistent bits
    logic [1:0] sector_guard_config_reg_mode; // sector_guard_config_reg[2:1]
    logic [63:0] password; // hidden password
    logic [63:0] pwd_entry; // password supplied by host
    logic [31:0] arg; // command argument
    logic status_write_disable; // status write disable bit
    logic fail; // last operation failed
    logic lock_rst_done; // lock initialised after reset
    fsp_state_t state; // sequencer state
    logic [31:0] timer; // busy countdown
    fsp_cmd_t pend_cmd; // command being executed
    logic [SW-1:0] pend_sec; // sector of pending program

    // bus decode
    logic wr_stb;
    logic [SW-1:0] arg_sec;
    logic pwmode;
    logic busy;
    logic cmd_go;
    fsp_cmd_t cmd;
    logic sector_guard_config_reg_go; // mode program may start
    logic sector_guard_config_reg_bad; // mode program must fail

    // mode value legal and echoed by the command word
    function automatic logic mode_value_ok(input logic [1:0] prog,
            input logic [1:0] echo);
        return (prog != MODE_ILLEGAL) && (prog == echo);
    endfunction

    assign wr_stb = psel && penable && pwrite;
    assign arg_sec = arg[SW-1:0];
    assign busy = (state != FSP_IDLE);
    assign pwmode = (sector_guard_config_reg_mode == MODE_PASS);
    assign cmd_go = wr_stb && (paddr == OFS_CMD) && !busy;
    assign cmd = fsp_cmd_t'(pwdata[3:0]);
    // only an unselected mode may be programmed
    assign sector_guard_config_reg_go = cmd_go && cmd == FSP_CMD_SECTOR_GUARD_CONFIG_REG_PROG &&
        sector_guard_config_reg_mode == MODE_NONE && !status_locked &&
        mode_value_ok(arg[2:1], pwdata[6:5]);
    assign sector_guard_config_reg_bad = cmd_go && cmd == FSP_CMD_SECTOR_GUARD_CONFIG_REG_PROG &&
        sector_guard_config_reg_mode == MODE_NONE && !mode_value_ok(arg[2:1], pwdata[6:5]);

    // single cycle apb answer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pready <= 1'b0;
        end else begin
            pready <= psel && !penable;
        end
    end

    // addresses above OFS_PROT return an error
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= psel && !penable && (paddr > OFS_PROT);
        end
    end

    // read data mux, registered for the access phase
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            unique case (paddr)
                OFS_ARG: prdata <= arg;
                OFS_STATUS: prdata <= {27'h0, status_locked, pwmode,
                    persistent_bit_lock, fail, busy};
                OFS_CTRL: prdata <= {31'h0, status_write_disable};
                OFS_SECTOR_GUARD_CONFIG_REG: prdata <= {29'h0, sector_guard_config_reg_mode, 1'b1};
                OFS_PSB_RD: prdata <= {31'h0, persistent_sector_bit[arg_sec]};
                OFS_DSB_RD: prdata <= {31'h0, dynamic_sector_bit[arg_sec]};
                OFS_PROT: prdata <= {31'h0, sector_protected[arg_sec]};
                // password hidden once any mode is chosen
                OFS_PWD_LO: prdata <= (sector_guard_config_reg_mode == MODE_NONE) ?
                    password[31:0] : 32'h0;
                OFS_PWD_HI: prdata <= (sector_guard_config_reg_mode == MODE_NONE) ?
                    password[63:32] : 32'h0;
                default: prdata <= 32'h0;
            endcase
        end
    end

    // argument and password entry registers
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            arg <= 32'h0;
            pwd_entry <= 64'h0;
        end else if (wr_stb) begin
            if (paddr == OFS_ARG) begin
                arg <= pwdata;
            end
            if (paddr == OFS_PWD_LO) begin
                pwd_entry[31:0] <= pwdata;
            end
            if (paddr == OFS_PWD_HI) begin
                pwd_entry[63:32] <= pwdata;
            end
        end
    end

    // status write disable, guarded by the pin
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            status_write_disable <= 1'b0;
        end else if (wr_stb && paddr == OFS_CTRL && !status_locked) begin
            status_write_disable <= pwdata[0];
        end
    end

    // status lock output
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            status_locked <= 1'b0;
        end else begin
            status_locked <= !write_protect_n && status_write_disable;
        end
    end

    // sequencer for timed operations
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= FSP_IDLE;
            timer <= 32'h0;
            pend_cmd <= FSP_CMD_NOP;
            pend_sec <= '0;
        end else begin
            unique case (state)
                FSP_IDLE: begin
                    if (cmd_go && cmd == FSP_CMD_PSB_PROG &&
                            persistent_bit_lock) begin
                        state <= FSP_BUSY;
                        timer <= 32'(PROG_CYC - 1);
                        pend_cmd <= cmd;
                        pend_sec <= arg_sec;
                    end else if (cmd_go && cmd == FSP_CMD_PSB_ERASE &&
                            persistent_bit_lock) begin
                        state <= FSP_PREPROG;
                        timer <= 32'(PROG_CYC - 1);
                        pend_cmd <= cmd;
                    end else if (sector_guard_config_reg_go) begin
                        state <= FSP_BUSY;
                        timer <= 32'(PROG_CYC - 1);
                        pend_cmd <= cmd;
                        pend_sec <= '0;
                    end
                end
                FSP_PREPROG: begin
                    if (timer == 32'h0) begin
                        state <= FSP_BUSY;
                        timer <= 32'(ERASE_CYC - 1);
                    end else begin
                        timer <= timer - 32'h1;
                    end
                end
                FSP_BUSY: begin
                    if (timer == 32'h0) begin
                        state <= FSP_IDLE;
                        pend_cmd <= FSP_CMD_NOP;
                    end else begin
                        timer <= timer - 32'h1;
                    end
                end
                default: state <= FSP_IDLE;
            endcase
        end
    end

    // progress flag readable throughout
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            write_in_progress <= 1'b0;
        end else begin
            write_in_progress <= busy || sector_guard_config_reg_go || (cmd_go &&
                persistent_bit_lock && (cmd == FSP_CMD_PSB_PROG ||
                cmd == FSP_CMD_PSB_ERASE));
        end
    end

    // failure flag for refused operations
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            fail <= 1'b0;
        end else if (cmd_go) begin
            if ((cmd == FSP_CMD_PSB_PROG || cmd == FSP_CMD_PSB_ERASE) &&
                    !persistent_bit_lock) begin
                fail <= 1'b1;
            end else if (sector_guard_config_reg_bad) begin
                fail <= 1'b1;
            end else if (cmd != FSP_CMD_NOP) begin
                fail <= 1'b0;
            end
        end
    end

    // persistent sector bits, updated at end of operation
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            persistent_sector_bit <= '1;
        end else if (state == FSP_BUSY && timer == 32'h0 &&
                persistent_bit_lock) begin
            // only while the lock is one
            if (pend_cmd == FSP_CMD_PSB_PROG) begin
                persistent_sector_bit[pend_sec] <= 1'b0;
            end else if (pend_cmd == FSP_CMD_PSB_ERASE) begin
                persistent_sector_bit <= '1;
            end
        end
    end

    // dynamic sector bits
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dynamic_sector_bit <= '1;
        end else if (cmd_go && cmd == FSP_CMD_SOFT_RST) begin
            dynamic_sector_bit <= '1;
        end else if (cmd_go && cmd == FSP_CMD_DSB_WRITE) begin
            dynamic_sector_bit[arg_sec] <= pwdata[8];
        end
    end

    // mode lock bits and password storage
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sector_guard_config_reg_mode <= SECTOR_GUARD_CONFIG_REG_MODE_RST;
            password <= PWD_RST;
        end else if (state == FSP_BUSY && timer == 32'h0 &&
                pend_cmd == FSP_CMD_SECTOR_GUARD_CONFIG_REG_PROG) begin
            sector_guard_config_reg_mode <= arg[2:1] & sector_guard_config_reg_mode;
        end else if (cmd_go && cmd == FSP_CMD_PWD_PROG &&
                sector_guard_config_reg_mode == MODE_NONE) begin
            password <= password & pwd_entry;
        end
    end

    // lock bit, initialised from the mode after reset
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            persistent_bit_lock <= 1'b0;
            lock_rst_done <= 1'b0;
        end else if (!lock_rst_done) begin
            lock_rst_done <= 1'b1;
            persistent_bit_lock <= !pwmode;
        end else if (cmd_go && cmd == FSP_CMD_LOCK_CLR) begin
            persistent_bit_lock <= 1'b0;
        end else if (cmd_go && cmd == FSP_CMD_PWD_UNLOCK && pwmode &&
                pwd_entry == password) begin
            persistent_bit_lock <= 1'b1;
        end
        // soft reset leaves the lock alone
    end

    // effective sector protection
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sector_protected <= '0;
        end else begin
            sector_protected <= bp_protect | ~persistent_sector_bit |
                ~dynamic_sector_bit;
        end
    end

    // mode program: arg[2:1] is the value written, pwdata[6:5] must echo
    // it, so a stray command word can never land the illegal code 00
endmodule

// File: verilog/fsp_pkg.sv
/*
 * fsp_pkg: constants shared by the flash sector protection logic.
 * assumes a 200 MHz system clock; register offsets are byte addresses
 * on a 32-bit APB bus.
 */
package fsp_pkg;
    // clock period in ns
    localparam int CLK_PERIOD_NS = 5;
    // typical page program time in us
    localparam int PAGE_PROG_US = 250;
    // typical sector erase time in us
    localparam int SECTOR_ERASE_US = 1000;
    // cycle counts derived from the times
    localparam int PAGE_PROG_CYC = PAGE_PROG_US * 1000 / CLK_PERIOD_NS;
    localparam int SECTOR_ERASE_CYC = SECTOR_ERASE_US * 1000 / CLK_PERIOD_NS;
    // register byte offsets
    localparam logic [7:0] OFS_CMD = 8'h00;
    localparam logic [7:0] OFS_ARG = 8'h04;
    localparam logic [7:0] OFS_PWD_LO = 8'h08;
    localparam logic [7:0] OFS_PWD_HI = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam logic [7:0] OFS_CTRL = 8'h14;
    localparam logic [7:0] OFS_SECTOR_GUARD_CONFIG_REG = 8'h18;
    localparam logic [7:0] OFS_PSB_RD = 8'h1c;
    localparam logic [7:0] OFS_DSB_RD = 8'h20;
    localparam logic [7:0] OFS_PROT = 8'h24;
    // status bit positions
    localparam int ST_WIP = 0;
    localparam int ST_FAIL = 1;
    localparam int ST_LOCK = 2;
    localparam int ST_PWMODE = 3;
    localparam int ST_SRLOCK = 4;
    // mode lock encodings in sector_guard_config_reg[2:1]
    localparam logic [1:0] MODE_NONE = 2'h3;
    localparam logic [1:0] MODE_PERS = 2'h2;
    localparam logic [1:0] MODE_PASS = 2'h1;
    localparam logic [1:0] MODE_ILLEGAL = 2'h0;
    // reset values
    localparam logic [1:0] SECTOR_GUARD_CONFIG_REG_MODE_RST = 2'h3;
    localparam logic [63:0] PWD_RST = 64'hffff_ffff_ffff_ffff;
    // commands written to the command register
    typedef enum logic [3:0] {
        FSP_CMD_NOP = 4'h0,
        FSP_CMD_PSB_PROG = 4'h1,
        FSP_CMD_PSB_ERASE = 4'h2,
        FSP_CMD_LOCK_CLR = 4'h3,
        FSP_CMD_PWD_UNLOCK = 4'h4,
        FSP_CMD_DSB_WRITE = 4'h5,
        FSP_CMD_SECTOR_GUARD_CONFIG_REG_PROG = 4'h6,
        FSP_CMD_PWD_PROG = 4'h7,
        FSP_CMD_SOFT_RST = 4'h8,
        FSP_CMD_STATUS_WR = 4'h9
    } fsp_cmd_t;
    // sequencer states
    typedef enum logic [1:0] {
        FSP_IDLE = 2'b00,
        FSP_PREPROG = 2'b01,
        FSP_BUSY = 2'b10
    } fsp_state_t;
endpackage

// File: bench/fsp_top_properties.sv
/* fsp_top_properties: timing checks on the fsp_top ports.
   assumes one clock clk_sys and rst_n async active low. */
`timescale 1ns/1ps
module fsp_top_properties #(
    parameter int SECTORS = 64,
    parameter int PROG_CYC = 4,
    parameter int ERASE_CYC = 8
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // protection
    input wire logic write_protect_n,
    input wire logic [SECTORS-1:0] bp_protect,
    input wire logic [SECTORS-1:0] sector_protected,
    input wire logic write_in_progress,
    input wire logic status_locked
);
    // longest busy span, erase with preprogram
    localparam int MAX_BUSY = PROG_CYC + ERASE_CYC + 2;
    logic [1:0] age; // edges since reset, saturating
    logic wr_q; // an apb write ended at the last edge
    int busy_cnt; // edges seen inside the busy span
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // history for the checks below
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            age <= 2'h0;
            wr_q <= 1'b0;
            busy_cnt <= 0;
        end else begin
            age <= (age == 2'h3) ? age : age + 2'h1;
            wr_q <= psel && penable && pwrite;
            busy_cnt <= write_in_progress ? busy_cnt + 1 : 0;
        end
    end
    pready_timing_a: assert property (psel && !penable |=> pready)
        else $error("pready missing in access cycle");
    slverr_map_a: assert property (pready |-> pslverr == (paddr > 8'h24))
        else $error("pslverr not matching address map");
    status_lock_a: assert property (status_locked |-> !$past(write_protect_n))
        else $error("status locked with pin high");
    block_or_a: assert property (age == 2'h3 |->
        (sector_protected & $past(bp_protect)) == $past(bp_protect))
        else $error("block protected sector not protected");
    prot_cause_a: assert property (
        age == 2'h3 && $changed(sector_protected)
        |-> $past(bp_protect) != $past(bp_protect, 2) || $past(wr_q)
        || $past(wr_q, 2) || $past(write_in_progress))
        else $error("sector protection changed without cause");
    busy_cause_a: assert property ($rose(write_in_progress) |->
        $past(psel) && $past(penable) && $past(pwrite)
        && $past(paddr) == 8'h00)
        else $error("busy rose without command write");
    busy_bound_a: assert property ($rose(write_in_progress)
        |-> ##[1:MAX_BUSY] !write_in_progress)
        else $error("busy span too long");
    busy_min_a: assert property ($fell(write_in_progress)
        |-> busy_cnt >= PROG_CYC - 1)
        else $error("busy span shorter than program time");
endmodule
bind fsp_top fsp_top_properties #(.SECTORS(SECTORS), .PROG_CYC(PROG_CYC),
    .ERASE_CYC(ERASE_CYC)) i_fsp_top_properties (.clk_sys(clk_sys),
    .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .write_protect_n(write_protect_n),
    .bp_protect(bp_protect), .sector_protected(sector_protected),
    .write_in_progress(write_in_progress), .status_locked(status_locked));

// File: bench/fsp_host.sv
/* fsp_host: apb master standing for the host controller.
   assumes a zero or more wait state slave on clk_sys. */
`timescale 1ns/1ps
module fsp_host (
    // clock
    input wire logic clk_sys,
    // apb master
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    import fsp_pkg::*;
    int hangs = 0; // waits that ran out
    // bus idle at time zero
    initial begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
    end
    // one transfer: setup, then access until pready
    task automatic xfer(input logic w, input logic [7:0] a,
        input logic [31:0] d, output logic [31:0] q, output logic e);
        int n;
        n = 0;
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        do begin
            @(posedge clk_sys);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) hangs++;
        q = prdata;
        e = pslverr;
        // released lines show the inverse of their last value
        psel <= 1'b0;
        penable <= 1'b0;
        paddr <= ~a;
        pwdata <= ~d;
    endtask
    // command write, then poll until busy clears
    task automatic cmd(input logic [31:0] d);
        logic [31:0] q;
        logic e;
        xfer(1'b1, OFS_CMD, d, q, e);
        for (int n = 0; n < 64; n++) begin
            xfer(1'b0, OFS_STATUS, 32'h0, q, e);
            if (q[ST_WIP] === 1'b0) break;
        end
        if (q[ST_WIP] !== 1'b0) hangs++;
    endtask
endmodule

// File: bench/testbench.sv
/* testbench: scenarios for fsp_top through the host model.
   assumes short program and erase counts of 4 and 8 cycles. */
`timescale 1ns/1ps
module testbench;
    import fsp_pkg::*;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    logic write_protect_n = 1'b1; // pin released
    logic [7:0] bp_protect = 8'h00; // no block protection
    logic [7:0] sector_protected;
    logic write_in_progress, status_locked;
    int mismatches = 0;
    int check_count = 0;
    // 200 MHz clock
    always #2.5 clk_sys = ~clk_sys;
    fsp_top #(.SECTORS(8), .PROG_CYC(4), .ERASE_CYC(8)) i_fsp_top (
        .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr),
        .write_protect_n(write_protect_n), .bp_protect(bp_protect),
        .sector_protected(sector_protected),
        .write_in_progress(write_in_progress),
        .status_locked(status_locked));
    fsp_host i_fsp_host (.clk_sys(clk_sys), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr));
    task automatic final_report();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    // a wait that ran out ends the run
    task automatic guard();
        if (i_fsp_host.hangs != 0) begin
            mismatches++;
            $display("mismatch at %0t: bus wait ran out", $time);
            final_report();
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        i_fsp_host.xfer(1'b1, a, d, q, e);
        guard();
    endtask
    task automatic hcmd(input logic [31:0] d);
        i_fsp_host.cmd(d);
        guard();
    endtask
    // read and compare the masked word
    task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
        input logic [31:0] x);
        i_fsp_host.xfer(1'b0, a, 32'h0, q, e);
        guard();
        check(q & m, x);
    endtask
    // power-on state of the guard logic
    task automatic sc_reset();
        rd_chk(OFS_STATUS, 32'h1f, 32'h4);
        rd_chk(OFS_SECTOR_GUARD_CONFIG_REG, 32'h7, 32'h7);
        rd_chk(OFS_DSB_RD, 32'h1, 32'h1);
        check({24'h0, sector_protected}, 32'h0);
        i_fsp_host.xfer(1'b0, 8'h28, 32'h0, q, e);
        check({31'h0, e}, 32'h1);
    endtask
    // volatile bits and block protection
    task automatic sc_dynamic();
        wr(OFS_ARG, 32'h2);
        hcmd(32'h5);
        check({24'h0, sector_protected}, 32'h4);
        rd_chk(OFS_DSB_RD, 32'h1, 32'h0);
        @(posedge clk_sys);
        bp_protect <= 8'h80;
        hcmd(32'h105);
        check({24'h0, sector_protected}, 32'h80);
        @(posedge clk_sys);
        bp_protect <= 8'h00;
    endtask
    // persistent bits: single program, group erase
    task automatic sc_persist();
        wr(OFS_ARG, 32'h1);
        wr(OFS_CMD, 32'h1);
        // busy flag is launched at the command edge, look one later
        @(posedge clk_sys);
        check({31'h0, write_in_progress}, 32'h1);
        // a no-op command only waits for the program to end
        hcmd(32'h0);
        check({31'h0, write_in_progress}, 32'h0);
        wr(OFS_ARG, 32'h3);
        hcmd(32'h1);
        check({24'h0, sector_protected}, 32'ha);
        rd_chk(OFS_PSB_RD, 32'h1, 32'h0);
        hcmd(32'h2);
        check({24'h0, sector_protected}, 32'h0);
        rd_chk(OFS_PSB_RD, 32'h1, 32'h1);
    endtask
    // pin and disable bit freeze the control register
    task automatic sc_status_lock();
        wr(OFS_CTRL, 32'h1);
        @(posedge clk_sys);
        write_protect_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        check({31'h0, status_locked}, 32'h1);
        wr(OFS_CTRL, 32'h0);
        rd_chk(OFS_CTRL, 32'h1, 32'h1);
        @(posedge clk_sys);
        write_protect_n <= 1'b1;
        wr(OFS_CTRL, 32'h0);
        rd_chk(OFS_CTRL, 32'h1, 32'h0);
    endtask
    // lock cleared: refused program, soft reset keeps lock
    task automatic sc_lock();
        wr(OFS_ARG, 32'h5);
        hcmd(32'h5);
        hcmd(32'h3);
        // a matching password must not set the lock outside password mode
        wr(OFS_PWD_LO, 32'hffff_ffff);
        wr(OFS_PWD_HI, 32'hffff_ffff);
        hcmd(32'h4);
        rd_chk(OFS_STATUS, 32'h4, 32'h0);
        wr(OFS_ARG, 32'h0);
        hcmd(32'h1);
        rd_chk(OFS_STATUS, 32'h1f, 32'h2);
        check({24'h0, sector_protected}, 32'h20);
        hcmd(32'h8);
        rd_chk(OFS_STATUS, 32'h1f, 32'h0);
        check({24'h0, sector_protected}, 32'h0);
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        rd_chk(OFS_STATUS, 32'h4, 32'h4);
    endtask
    // password mode selection and unlock
    task automatic sc_password();
        // password stored before the mode bits
        wr(OFS_PWD_LO, 32'h1234_5678);
        wr(OFS_PWD_HI, 32'h0bad_cafe);
        hcmd(32'h7);
        wr(OFS_ARG, 32'h0);
        hcmd(32'h6);
        rd_chk(OFS_STATUS, 32'h2, 32'h2);
        wr(OFS_ARG, 32'h2);
        hcmd(32'h26);
        rd_chk(OFS_SECTOR_GUARD_CONFIG_REG, 32'h7, 32'h3);
        wr(OFS_ARG, 32'h4);
        hcmd(32'h46);
        rd_chk(OFS_SECTOR_GUARD_CONFIG_REG, 32'h7, 32'h3);
        hcmd(32'h3);
        rd_chk(OFS_STATUS, 32'hc, 32'h8);
        wr(OFS_PWD_LO, 32'h1234_5679);
        hcmd(32'h4);
        rd_chk(OFS_STATUS, 32'h4, 32'h0);
        wr(OFS_PWD_LO, 32'h1234_5678);
        hcmd(32'h4);
        rd_chk(OFS_STATUS, 32'h4, 32'h4);
    endtask
    // main sequence
    initial begin
        repeat (20) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        sc_reset();
        sc_dynamic();
        sc_persist();
        sc_status_lock();
        sc_lock();
        sc_password();
        final_report();
    end
endmodule
